/* File: csr_pkg.sv */
// Constants shared by the conversion start and reset controller.
// Assumes a 50 MHz pclk and APB access from a 32-bit master.
//
// Contract
// - Pin low longer than two-to-the-ninth modulator periods powers the device down.
// - Every falling edge of the power-down/reset pin resets, before any power-down.
// - Reset opcode acts on the eighth falling serial clock edge of its byte.
// - Reset takes 18 device clocks to restore defaults, then conversion cycle begins.
// - Writing a new value to main or respiration registers resets the filter.
// - Start pin low and no start opcode means halted, no data-ready fall.
// - Single-shot bit 7 of main configuration selects continuous or single-shot mode.
// - Start drives data-ready high; next falling edge marks first settled result.
// - Settling time per rate select code, 4100 down to 68 modulator periods.
// - Modulator period is 4 device clocks, or 16 with clock divider set.
// - After a step, the fourth data-ready pulse carries the first settled result.
// - Continuous conversions repeat until stop; conversion in progress is finished.
// - Start and stop opcodes act on the seventh falling serial clock edge.
// - Single-shot gives one conversion; data-ready stays low; no further conversions.
// - Each single-shot start resets the filter, quartering the effective rate.
// - Oscillator-by-pin plus clock output bit set lets this device feed others.
package csr_pkg;

   // Register byte addresses.
   localparam logic [7:0] ADDR_MAIN   = 8'h00;
   localparam logic [7:0] ADDR_RESP_A = 8'h04;
   localparam logic [7:0] ADDR_RESP_B = 8'h08;
   localparam logic [7:0] ADDR_CTRL   = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // Field positions.
   localparam int SS_BIT       = 7;
   localparam int RATE_LSB     = 0;
   localparam int CLKDIV_BIT   = 0;
   localparam int CLKOUT_BIT   = 1;
   localparam int ST_RESULT_READY_N_BIT  = 0;
   localparam int ST_CONV_BIT  = 1;
   localparam int ST_PDN_BIT   = 2;
   localparam int ST_INIT_BIT  = 3;
   localparam int ST_SETL_BIT  = 4;

   // Reset values.
   localparam logic [7:0] MAIN_RST   = 8'h02;
   localparam logic [7:0] RESP_A_RST = 8'h00;
   localparam logic [7:0] RESP_B_RST = 8'h02;
   localparam logic [1:0] CTRL_RST   = 2'h0;

   // Timing, in device clocks or modulator periods.
   localparam int          INIT_TCLK      = 18;
   localparam logic [4:0]  INIT_LOAD      = 5'(INIT_TCLK);
   localparam logic [3:0]  MOD_LEN_DIV0   = 4'h4;
   localparam logic [3:0]  MOD_LEN_DIV1   = 4'hf + 4'h1 - 4'h0;
   localparam int          PD_MOD_PERIODS = 512;
   localparam logic [12:0] RESULT_READY_N_LEAD      = 13'h004;
   localparam logic [12:0] SETTLE_OVH     = 13'h004;
   localparam logic [2:0]  SETTLED_PULSES = 3'h4;

   localparam logic [12:0] SETTLE_TAB [8] = '{
      13'h1004, 13'h0804, 13'h0404, 13'h0204,
      13'h0104, 13'h0084, 13'h0044, 13'h0044};

   typedef enum logic [1:0] {ST_PDN, ST_INIT, ST_IDLE, ST_CONV} csr_state_e;

endpackage : csr_pkg

/* File: csr_ctrl.sv */
// Conversion start, reset and power-down sequencing with an APB slave.
// Pins and opcode pulses arrive synchronous to pclk; the serial decoder
// pulses the opcode inputs on the proper falling serial clock edge.
module csr_ctrl
   import csr_pkg::*;
#(
   parameter int PD_MODS = PD_MOD_PERIODS,
   parameter int ADDR_W  = 12
) (
   // Clock and reset.
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Device pins.
   input  wire logic              powerdown_reset_pin,
   input  wire logic              start_pin,
   input  wire logic              osc_source_pin,
   // Opcode and read events from the serial decoder.
   input  wire logic              cmd_reset_pulse,
   input  wire logic              cmd_start_pulse,
   input  wire logic              cmd_stop_pulse,
   input  wire logic              data_read_pulse,
   // Status outputs.
   output logic                   result_ready_n,
   output logic                   converting,
   output logic                   powered_down,
   output logic                   init_busy,
   output logic                   filter_reset,
   output logic                   clk_share_en
);

   if (PD_MODS < 1 || PD_MODS > 65534) begin : g_bad_pd
      $error("PD_MODS out of range");
   end
   if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
   end

   function automatic logic [12:0] settle_of(input logic [2:0] rate);
      settle_of = SETTLE_TAB[rate];
   endfunction : settle_of

   // Data period in modulator periods, one quarter of the settle payload.
   function automatic logic [12:0] period_of(input logic [2:0] rate);
      logic [12:0] s;
      s = SETTLE_TAB[rate] - SETTLE_OVH;
      period_of = {2'b00, s[12:2]};
   endfunction : period_of

   localparam logic [15:0] PD_LIM = 16'(PD_MODS);

   csr_state_e  state_q, state_d;
   logic [12:0] conv_q, conv_d;
   logic [4:0]  init_q, init_d;
   logic [15:0] pd_q;
   logic [3:0]  pre_q;
   logic [2:0]  nres_q, nres_d;
   logic        result_ready_n_q, result_ready_n_d;
   logic        ss_q, ss_d;
   logic        fr_d;
   logic        pin_prev_q, start_prev_q, cmd_run_q;
   logic [7:0]  main_q, resp_a_q, resp_b_q;
   logic [1:0]  ctrl_q;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q;
   logic        fr_q, pdn_q, conv_o_q, init_o_q, share_q;

   // Bus decode.
   wire [7:0] a8        = paddr[7:0];
   wire       hi_zero   = (paddr >> 8) == '0;
   wire       hit_main  = hi_zero && a8 == ADDR_MAIN;
   wire       hit_ra    = hi_zero && a8 == ADDR_RESP_A;
   wire       hit_rb    = hi_zero && a8 == ADDR_RESP_B;
   wire       hit_ctrl  = hi_zero && a8 == ADDR_CTRL;
   wire       hit_st    = hi_zero && a8 == ADDR_STATUS;
   wire       hit_any   = hit_main | hit_ra | hit_rb | hit_ctrl | hit_st;
   wire       acc_wait  = psel & penable & ~pready_q;
   wire       acc_done  = psel & penable & pready_q;
   wire       regs_hold = state_q == ST_INIT || state_q == ST_PDN;
   wire       wr_ok     = acc_done & pwrite & ~regs_hold;
   wire [7:0] wbyte     = pwdata[7:0];
   wire       wr_main   = wr_ok & hit_main;
   wire       wr_ra     = wr_ok & hit_ra;
   wire       wr_rb     = wr_ok & hit_rb;
   wire       wr_ctrl   = wr_ok & hit_ctrl;

   // A rewrite of an unchanged value leaves the filter running.
   wire filt_wr = (wr_main & (wbyte != main_q)) |
                  (wr_ra & (wbyte != resp_a_q)) |
                  (wr_rb & (wbyte != resp_b_q));

   wire [7:0] status_w = 8'({(nres_q == SETTLED_PULSES), init_o_q,
                             pdn_q, conv_o_q, result_ready_n_q});
   wire [7:0] rd_byte  = hit_main ? main_q :
                         hit_ra   ? resp_a_q :
                         hit_rb   ? resp_b_q :
                         hit_ctrl ? {6'h00, ctrl_q} :
                         hit_st   ? status_w : 8'h00;

   // Sequencing events.
   wire       pin_fall  = pin_prev_q & ~powerdown_reset_pin;
   wire       reset_evt = pin_fall | cmd_reset_pulse;
   wire       pin_rise  = start_pin & ~start_prev_q;
   wire       start_evt = pin_rise | cmd_start_pulse;
   wire       run_req   = start_pin | cmd_run_q;
   wire [3:0] mod_len   = ctrl_q[CLKDIV_BIT] ? MOD_LEN_DIV1 : MOD_LEN_DIV0;
   wire       mod_tick  = pre_q == mod_len - 4'h1;
   wire       pd_hit    = pd_q > PD_LIM;
   wire [2:0] rate      = main_q[RATE_LSB +: 3];

   always_comb begin
      state_d = state_q;
      conv_d  = conv_q;
      init_d  = init_q;
      result_ready_n_d  = result_ready_n_q;
      ss_d    = ss_q;
      nres_d  = nres_q;
      fr_d    = filt_wr;
      unique case (state_q)
         ST_PDN: begin
            if (powerdown_reset_pin) begin
               state_d = ST_INIT;
               init_d  = INIT_LOAD;
            end
         end
         ST_INIT: begin
            result_ready_n_d = 1'b1;
            if (!powerdown_reset_pin && pd_hit) begin
               state_d = ST_PDN;
            end else if (!powerdown_reset_pin) begin
               init_d = INIT_LOAD;
            end else if (init_q == 5'h01) begin
               state_d = ST_IDLE;
               if (run_req) begin
                  state_d = ST_CONV;
                  conv_d  = settle_of(rate);
                  ss_d    = main_q[SS_BIT];
                  fr_d    = 1'b1;
                  nres_d  = 3'h0;
               end
            end else begin
               init_d = init_q - 5'h01;
            end
         end
         ST_IDLE: begin
            if (start_evt) begin
               state_d = ST_CONV;
               conv_d  = settle_of(rate);
               result_ready_n_d  = 1'b1;
               ss_d    = main_q[SS_BIT];
               fr_d    = 1'b1;
               nres_d  = 3'h0;
            end else if (data_read_pulse && !ss_q) begin
               result_ready_n_d = 1'b1;
            end
         end
         ST_CONV: begin
            if (pin_rise || filt_wr) begin
               conv_d = settle_of(rate);
               result_ready_n_d = 1'b1;
               fr_d   = 1'b1;
               ss_d   = main_q[SS_BIT];
               nres_d = 3'h0;
            end else if (mod_tick && conv_q == 13'h0001) begin
               result_ready_n_d = 1'b0;
               if (nres_q != SETTLED_PULSES) begin
                  nres_d = nres_q + 3'h1;
               end
               if (ss_q || !run_req) begin
                  state_d = ST_IDLE;
               end else begin
                  conv_d = period_of(rate);
               end
            end else begin
               if (mod_tick) begin
                  conv_d = conv_q - 13'h0001;
               end
               // Rising ahead of the result keeps every result an edge.
               if (!ss_q && mod_tick && conv_q == RESULT_READY_N_LEAD + 13'h0001) begin
                  result_ready_n_d = 1'b1;
               end
               if (!ss_q && data_read_pulse) begin
                  result_ready_n_d = 1'b1;
               end
            end
         end
      endcase
      if (reset_evt) begin
         state_d = ST_INIT;
         init_d  = INIT_LOAD;
         result_ready_n_d  = 1'b1;
         fr_d    = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_INIT;
         conv_q  <= 13'h0000;
         init_q  <= INIT_LOAD;
         result_ready_n_q  <= 1'b1;
         ss_q    <= 1'b0;
         nres_q  <= 3'h0;
         fr_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         conv_q  <= conv_d;
         init_q  <= init_d;
         result_ready_n_q  <= result_ready_n_d;
         ss_q    <= ss_d;
         nres_q  <= nres_d;
         fr_q    <= fr_d;
      end
   end

   // Edge history, opcode run flag, prescaler and power-down counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev_q   <= 1'b1;
         start_prev_q <= 1'b0;
         cmd_run_q    <= 1'b0;
         pre_q        <= 4'h0;
         pd_q         <= 16'h0000;
      end else begin
         pin_prev_q   <= powerdown_reset_pin;
         start_prev_q <= start_pin;
         // A start in the same cycle as a stop wins.
         cmd_run_q    <= reset_evt ? 1'b0 :
                         cmd_start_pulse ? 1'b1 :
                         cmd_stop_pulse ? 1'b0 : cmd_run_q;
         pre_q        <= mod_tick ? 4'h0 : pre_q + 4'h1;
         if (powerdown_reset_pin) begin
            pd_q <= 16'h0000;
         end else if (mod_tick && !pd_hit) begin
            pd_q <= pd_q + 16'h0001;
         end
      end
   end

   // Configuration is lost on every reset and must be rewritten.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_q   <= MAIN_RST;
         resp_a_q <= RESP_A_RST;
         resp_b_q <= RESP_B_RST;
         ctrl_q   <= CTRL_RST;
      end else if (regs_hold || reset_evt) begin
         main_q   <= MAIN_RST;
         resp_a_q <= RESP_A_RST;
         resp_b_q <= RESP_B_RST;
         ctrl_q   <= CTRL_RST;
      end else begin
         if (wr_main) main_q <= wbyte;
         if (wr_ra) resp_a_q <= wbyte;
         if (wr_rb) resp_b_q <= wbyte;
         if (wr_ctrl) ctrl_q <= wbyte[1:0];
      end
   end

   // One wait state: data and error are prepared in the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         pdn_q     <= 1'b0;
         conv_o_q  <= 1'b0;
         init_o_q  <= 1'b1;
         share_q   <= 1'b0;
      end else begin
         prdata_q  <= acc_wait ? {24'h000000, rd_byte} : 32'h0000_0000;
         pready_q  <= acc_wait;
         pslverr_q <= acc_wait & ~hit_any;
         pdn_q     <= state_d == ST_PDN;
         conv_o_q  <= state_d == ST_CONV;
         init_o_q  <= state_d == ST_INIT;
         share_q   <= osc_source_pin & ctrl_q[CLKOUT_BIT];
      end
   end

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign result_ready_n = result_ready_n_q;
   assign converting     = conv_o_q;
   assign powered_down   = pdn_q;
   assign init_busy      = init_o_q;
   assign filter_reset   = fr_q;
   assign clk_share_en   = share_q;

   // Helper: cycles spent in the initialisation state before this one.
   logic [5:0] init_run_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_run_q <= 6'h00;
      end else if (state_q == ST_INIT && powerdown_reset_pin && !reset_evt) begin
         init_run_q <= init_run_q + 6'h01;
      end else begin
         init_run_q <= 6'h00;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fall_resets: assert property (pin_fall |=> state_q == ST_INIT && init_busy)
      else $error("pin falling edge did not reset");
   a_pd_entry: assert property (
      state_q == ST_INIT && !powerdown_reset_pin && pd_hit && !cmd_reset_pulse
      |=> powered_down)
      else $error("long low pin did not power down");
   a_short_no_pd: assert property (
      !pd_hit && state_q == ST_INIT |=> !powered_down)
      else $error("short pulse powered the device down");
   a_cmd_reset: assert property (cmd_reset_pulse |=> init_busy && result_ready_n)
      else $error("reset opcode ignored");
   a_init_len: assert property (
      state_q == ST_INIT && $past(state_q) == ST_INIT && init_run_q != 6'h00
      && state_d != ST_INIT && state_d != ST_PDN && !reset_evt
      |-> init_run_q == 6'(INIT_TCLK - 1))
      else $error("initialisation not 18 clocks");
   a_filt_write: assert property (filt_wr |=> filter_reset)
      else $error("config change did not reset filter");
   a_halt_quiet: assert property (
      $fell(result_ready_n) |-> $past(state_q) == ST_CONV)
      else $error("data ready fell while halted");
   a_start_high: assert property (
      state_q == ST_IDLE && start_evt && !reset_evt
      |=> result_ready_n && converting && filter_reset)
      else $error("start did not raise data ready");
   a_mod_len: assert property (
      mod_tick && !ctrl_q[CLKDIV_BIT]
      |=> !mod_tick [*3] ##1 (mod_tick != ctrl_q[CLKDIV_BIT]))
      else $error("modulator period not 4 clocks");
   a_single_hold: assert property (
      state_q == ST_IDLE && ss_q && !result_ready_n && !start_evt && !reset_evt
      |=> !result_ready_n && !converting)
      else $error("single-shot data ready released");
   a_single_stop: assert property (
      $fell(result_ready_n) && ss_q |-> !converting ##1 !converting)
      else $error("single-shot conversion repeated");

   c_powerdown: cover property (powered_down ##1 !powered_down);
   c_continuous: cover property (
      $fell(result_ready_n) && !ss_q ##[1:300] $fell(result_ready_n));
   c_single: cover property ($fell(result_ready_n) && ss_q);
   c_filt_restart: cover property (converting && filt_wr);

endmodule : csr_ctrl

/* File: csr_host_model.sv */
// Host model that drives the control pins and the opcode events.
// Assumes the bench calls its tasks, one at a time, from a single process.
module csr_host_model (
   // Clock.
   input  wire logic pclk,
   // Control pins.
   output logic      powerdown_reset_pin,
   output logic      start_pin,
   output logic      osc_source_pin,
   // Opcode and read events.
   output logic      cmd_reset_pulse,
   output logic      cmd_start_pulse,
   output logic      cmd_stop_pulse,
   output logic      data_read_pulse
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      powerdown_reset_pin = 1'b1;
      start_pin           = 1'b0;
      osc_source_pin      = 1'b0;
      cmd_reset_pulse     = 1'b0;
      cmd_start_pulse     = 1'b0;
      cmd_stop_pulse      = 1'b0;
      data_read_pulse     = 1'b0;
   end

   // Code 0 resets, 1 starts, 2 stops. The start pin is not driven and keeps its level.
   task automatic opcode(input int code);
      @(posedge pclk);
      cmd_reset_pulse <= (code == 0);
      cmd_start_pulse <= (code == 1);
      cmd_stop_pulse  <= (code == 2);
      @(posedge pclk);
      cmd_reset_pulse <= 1'b0;
      cmd_start_pulse <= 1'b0;
      cmd_stop_pulse  <= 1'b0;
   endtask : opcode

   // A pin change lands on one edge; pulses of the start pin make a new shot.
   task automatic set_pin(input int which, input logic v);
      @(posedge pclk);
      if (which == 0) powerdown_reset_pin <= v;
      else if (which == 1) start_pin <= v;
      else osc_source_pin <= v;
   endtask : set_pin

   // One extra modulator period passes before data are clocked out.
   task automatic read_result(input int mod_clks);
      repeat (mod_clks) @(posedge pclk);
      data_read_pulse <= 1'b1;
      @(posedge pclk);
      data_read_pulse <= 1'b0;
   endtask : read_result
endmodule : csr_host_model

/* File: csr_ctrl_bench.sv */
// Self-checking bench for the conversion start and reset controller.
// Assumes the host model drives all pins; the power-down count is shortened.
module csr_ctrl_bench
   import csr_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PDM = 8;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic        pdr, stp, osc, c_rst, c_go, c_halt, rdp;
   logic        rrn, conv, pdn, busy, frst, share, e;
   int          n_fail, compares, n_frst;
   int          st[8] = '{4100, 2052, 1028, 516, 260, 132, 68, 68};

   csr_ctrl #(.PD_MODS(PDM)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .powerdown_reset_pin(pdr), .start_pin(stp), .osc_source_pin(osc),
      .cmd_reset_pulse(c_rst), .cmd_start_pulse(c_go),
      .cmd_stop_pulse(c_halt), .data_read_pulse(rdp),
      .result_ready_n(rrn), .converting(conv), .powered_down(pdn),
      .init_busy(busy), .filter_reset(frst), .clk_share_en(share));
   csr_host_model host_u (.pclk(pclk), .powerdown_reset_pin(pdr),
      .start_pin(stp), .osc_source_pin(osc), .cmd_reset_pulse(c_rst),
      .cmd_start_pulse(c_go), .cmd_stop_pulse(c_halt),
      .data_read_pulse(rdp));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) if (frst === 1'b1) n_frst++;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // The request is held until pready is sampled high, then released.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {4'h0, a};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
         $display("Error at %0t: no pready", $time);
         give_verdict();
      end
      rdv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic pick(input int w);
      return (w == 0) ? rrn : (w == 1) ? busy : pdn;
   endfunction : pick

   // Counts edges until the chosen output shows v; a bound cuts a hang.
   task automatic wait_on(input int w, input logic v, input int lim,
                          output int n);
      n = 0;
      while (pick(w) !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim) begin
         n_fail++;
         $display("Error at %0t: wait ran out", $time);
         give_verdict();
      end
   endtask : wait_on

   task automatic t_regs();
      logic [7:0] ad[4] = '{ADDR_MAIN, ADDR_RESP_A, ADDR_RESP_B, ADDR_CTRL};
      logic [7:0] rv[4] = '{MAIN_RST, RESP_A_RST, RESP_B_RST, 8'h00};
      int bad;
      bad = 0;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ad[i], 32'h0);
         chk(rdv, {24'h0, rv[i]});
      end
      apb(1'b0, 8'h14, 32'h0);
      chk({rdv[30:0], e}, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rdv[3:0], 32'h1);
      repeat (300) begin
         @(posedge pclk);
         if (rrn !== 1'b1 || conv !== 1'b0) bad++;
      end
      chk(bad, 0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ADDR_CTRL, 32'(i[1]) << CLKOUT_BIT);
         host_u.set_pin(2, i[0]);
         repeat (3) @(posedge pclk);
         chk(share, i == 3);
      end
   endtask : t_regs

   // Every rate code in single-shot mode at four clocks per period.
   task automatic t_rates();
      int n, bad;
      apb(1'b1, ADDR_CTRL, 32'h0);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, ADDR_MAIN, 32'h80 | c);
         host_u.opcode(1);
         @(posedge pclk);
         chk({rrn, conv, frst}, 32'h7);
         wait_on(0, 1'b0, 17000, n);
         chk(n >= 4 * st[c] - 4 && n <= 4 * st[c] + 12, 1);
         host_u.read_result(4);
         bad = 0;
         repeat (60) begin
            @(posedge pclk);
            if (rrn !== 1'b0 || conv !== 1'b0) bad++;
         end
         chk(bad, 0);
      end
      // Opcode control ends with a stop before the pin takes over again.
      host_u.opcode(2);
   endtask : t_rates

   // Continuous run by pin at sixteen clocks per period, then a stop.
   task automatic t_cont();
      int n, m, bad;
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b1, ADDR_MAIN, 32'h06);
      host_u.set_pin(1, 1'b1);
      wait_on(0, 1'b1, 10, n);
      wait_on(0, 1'b0, 1200, n);
      chk(n >= 16 * 67 && n <= 16 * 70, 1);
      for (int i = 2; i <= 4; i++) begin
         host_u.read_result(16);
         wait_on(0, 1'b1, 20, m);
         wait_on(0, 1'b0, 400, n);
         chk(m + n >= 16 * 16 - 40 && m + n <= 16 * 16, 1);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk(rdv[ST_SETL_BIT], i == 4);
      end
      host_u.set_pin(1, 1'b0);
      wait_on(0, 1'b1, 400, n);
      wait_on(0, 1'b0, 400, n);
      bad = 0;
      repeat (600) begin
         @(posedge pclk);
         if (rrn !== 1'b0 || conv !== 1'b0) bad++;
      end
      chk(bad, 0);
   endtask : t_cont

   task automatic t_filter();
      logic [7:0] ad[3] = '{ADDR_MAIN, ADDR_RESP_A, ADDR_RESP_B};
      int b, n;
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 2; k++) begin
            b = n_frst;
            apb(1'b1, ad[i], 32'h05);
            repeat (4) @(posedge pclk);
            chk(n_frst - b, k == 0);
         end
      end
      // A changed setting in mid-conversion restarts the settling count.
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_MAIN, 32'h86);
      host_u.opcode(1);
      repeat (100) @(posedge pclk);
      b = n_frst;
      apb(1'b1, ADDR_RESP_A, 32'h0a);
      wait_on(0, 1'b0, 400, n);
      chk(n >= 4 * st[6] - 4 && n <= 4 * st[6] + 4, 1);
      chk(n_frst - b, 1);
      host_u.opcode(2);
   endtask : t_filter

   task automatic t_reset();
      int n;
      apb(1'b1, ADDR_MAIN, 32'h86);
      host_u.opcode(0);
      @(posedge pclk);
      chk(busy, 1);
      wait_on(1, 1'b0, 40, n);
      chk(n >= 16 && n <= 19, 1);
      apb(1'b0, ADDR_MAIN, 32'h0);
      chk(rdv, 32'(MAIN_RST));
      host_u.set_pin(0, 1'b0);
      repeat (2 * PDM) @(posedge pclk);
      chk({busy, pdn}, 32'h2);
      host_u.set_pin(0, 1'b1);
      wait_on(1, 1'b0, 40, n);
      chk({busy, pdn}, 32'h0);
      apb(1'b1, ADDR_RESP_A, 32'h05);
      host_u.set_pin(0, 1'b0);
      @(posedge pclk);
      wait_on(2, 1'b1, 100, n);
      chk(n >= 4 * PDM - 2 && n <= 4 * PDM + 8, 1);
      host_u.set_pin(0, 1'b1);
      wait_on(2, 1'b0, 10, n);
      wait_on(1, 1'b0, 40, n);
      apb(1'b0, ADDR_RESP_A, 32'h0);
      chk(rdv, 32'(RESP_A_RST));
   endtask : t_reset

   initial begin
      int n;
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wait_on(1, 1'b0, 40, n);
      t_regs();
      t_rates();
      t_cont();
      t_filter();
      t_reset();
      give_verdict();
   end
endmodule : csr_ctrl_bench
